// ===== pkg/tsd_pkg.sv
package tsd_pkg;

  // Word addresses of the manual-mode DSP registers.
  localparam logic [15:0] TSD_ADDR_LINE_VOL   = 16'h0007;
  localparam logic [15:0] TSD_ADDR_SPK_ROUTE  = 16'h0008;
  localparam logic [15:0] TSD_ADDR_LINE_ROUTE = 16'h000A;
  localparam logic [15:0] TSD_ADDR_SER_ROUTE  = 16'h000B;
  localparam logic [15:0] TSD_ADDR_PEAK_ROUTE = 16'h000C;
  localparam logic [15:0] TSD_ADDR_FM_SOURCE_MATRIX  = 16'h000E;
  localparam logic [15:0] TSD_ADDR_DEEMPH     = 16'h000F;
  localparam logic [15:0] TSD_ADDR_IDENT      = 16'h0015;
  localparam logic [15:0] TSD_ADDR_DC_FILTER  = 16'h0017;
  localparam logic [15:0] TSD_ADDR_STEREO_LVL = 16'h0018;
  localparam logic [15:0] TSD_ADDR_FM_ONE_DC  = 16'h001B;
  localparam logic [15:0] TSD_ADDR_FM_TWO_DC  = 16'h001C;

  // Channel matrix codes held in the low byte of a routing word or of the Fm_source_matrix word.
  localparam logic [7:0] TSD_MX_SUM_DIFFERENCE_MODE = 8'h40;
  localparam logic [7:0] TSD_MX_SWAP     = 8'h50;
  localparam logic [7:0] TSD_MX_INV_B    = 8'h60;
  localparam logic [7:0] TSD_MX_INV_A    = 8'h70;
  localparam logic [7:0] TSD_MX_A_ONLY   = 8'h80;
  localparam logic [7:0] TSD_MX_B_ONLY   = 8'h90;
  localparam logic [7:0] TSD_FM_SOUND_A_MONO = 8'h03;

  // Line-out volume and volume law.
  localparam logic [7:0] TSD_VOL_UNITY  = 8'h40;
  localparam logic [3:0] TSD_LAW_LOG    = 4'h1;
  localparam int         TSD_VOL_SHIFT  = 6;

  // Deemphasis, identification and DC filter codes.
  localparam logic [7:0] TSD_DEEMPH_50US  = 8'h00;
  localparam logic [7:0] TSD_DEEMPH_75US  = 8'h01;
  localparam logic [7:0] TSD_DEEMPH_CURVE = 8'h04;
  localparam logic [7:0] TSD_CODE_OFF     = 8'h3F;
  localparam logic [7:0] TSD_IDENT_BG     = 8'h00;
  localparam logic [7:0] TSD_IDENT_M      = 8'h01;

  // Reset values of the write words.
  localparam logic [15:0] TSD_WORD_RESET = 16'h0000;

  // Settling time constant of the DC level measurement.
  localparam int TSD_DC_TAU_US = 28000;

  typedef logic signed [15:0] tsd_sample_t;

  typedef struct packed {
    tsd_sample_t a;
    tsd_sample_t b;
  } tsd_pair_t;

  // Values that a standard selection or automatic sound select loads.
  typedef struct packed {
    logic [7:0] deemph;
    logic [7:0] adaptive;
    logic [7:0] ident;
  } tsd_std_cfg_t;

endpackage

// ===== core/tsd_regs.sv
`timescale 1ns/10ps

// Functional notes
// - Routing low bytes accept six extra matrix codes.
// - Sum/difference puts sum on A, difference on B.
// - Line-out word: volume high byte, law low nibble.
// - Deemphasis high byte selects fixed curve, standard loads.
// - Adaptive low byte; auto select keeps settings updated.
// - Ident mode B/G or M; 0x3F clears filter.
// - NICAM path always uses fixed curve deemphasis.
// - DC filter word: 0x00 enables, 0x3F disables.
// - All register transfers are whole 16-bit words.
// - Read registers ignore writes.
// - Stereo level in high byte, two's complement.
// - DC levels of both FM channels, full words.
// - DC sign follows oscillator offset versus carrier.
// - DC readings settle with about 28 ms constant.
// - DC removed from FM before further processing.
// - Manual mode offers exactly two source channels.
// - NICAM enabled excludes second FM channel.
// - Adaptive deemphasis and identification are exclusive.
// - NICAM standards force Fm_source_matrix to mono A.
module tsd_regs
  import tsd_pkg::*;
#(
  parameter int FS_HZ = 32000
) (
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  input  wire logic            i_wr_stb,
  input  wire logic            i_rd_stb,
  input  wire logic [15:0]     i_addr,
  input  wire logic [15:0]     i_wdata,
  output logic                 o_rd_valid,
  output logic [15:0]          o_rdata,
  input  wire logic            i_std_load,
  input  wire logic            i_auto_upd,
  input  wire logic            i_auto_select,
  input  wire tsd_std_cfg_t    i_std_cfg,
  input  wire logic            i_nicam_std,
  input  wire logic            i_nicam_enable,
  input  wire tsd_pair_t [1:0] i_src,
  input  wire logic            i_src_valid,
  input  wire tsd_sample_t     i_fm_one,
  input  wire tsd_sample_t     i_fm_two,
  input  wire logic            i_fm_valid,
  input  wire logic [7:0]      i_stereo_level,
  output tsd_pair_t [3:0]      o_route,
  output logic                 o_route_valid,
  output tsd_sample_t          o_fm_one_clean,
  output tsd_sample_t          o_fm_two_clean,
  output logic                 o_fm_valid,
  output logic [7:0]           o_fm_deemph,
  output logic                 o_adaptive_deemph_on,
  output logic                 o_ident_eval_en,
  output logic                 o_ident_mode_m,
  output logic                 o_ident_filter_clear,
  output logic                 o_dc_filter_en,
  output logic                 o_nicam_curve_deemph,
  output logic                 o_fm_two_enable,
  output logic [7:0]           o_fm_source_matrix
);

  // Samples per time constant, and the shift that gives a one-pole filter of about that length.
  localparam longint DC_SAMPLES = (longint'(TSD_DC_TAU_US) * FS_HZ) / 1000000;
  localparam int     DC_SHIFT   = (DC_SAMPLES < 2) ? 1 : $clog2(DC_SAMPLES);

  typedef struct packed {
    logic [3:0][15:0] route_word;
    logic [15:0]      line_vol_word;
    logic [15:0]      fm_source_matrix_word;
    logic [15:0]      deemph_word;
    logic [15:0]      ident_word;
    logic [15:0]      dc_word;
    logic             ident_clear;
    logic [7:0]       stereo_lvl;
    logic [31:0]      acc_one;
    logic [31:0]      acc_two;
    tsd_pair_t [3:0]  route;
    logic             route_valid;
    tsd_sample_t      fm_one_clean;
    tsd_sample_t      fm_two_clean;
    logic             fm_valid;
    logic             rd_valid;
    logic [15:0]      rdata;
    logic             nicam_curve;
  } tsd_state_t;

  tsd_state_t state_r;
  tsd_state_t state_nxt;
  logic       rst_meta_r;
  logic       rst_n_r;

  // Saturate a 17-bit or wider result back to one sample.
  function automatic tsd_sample_t sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      sat16 = 16'sh7FFF;
    end else if (v < -32'sd32768) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // Negation that cannot overflow on the most negative sample.
  function automatic tsd_sample_t neg_sat(input tsd_sample_t x);
    neg_sat = sat16(-32'(x));
  endfunction

  // Apply one channel matrix code to a source pair.
  function automatic tsd_pair_t route_pair(input tsd_pair_t p, input logic [7:0] code);
    tsd_pair_t        r;
    logic signed [16:0] s;
    logic signed [16:0] d;
    r = p;
    s = 17'(p.a) + 17'(p.b);
    d = 17'(p.a) - 17'(p.b);
    // Halving sum and difference keeps them in range at the cost of 6 dB.
    case (code)
      TSD_MX_SUM_DIFFERENCE_MODE: begin
        r.a = s[16:1];
        r.b = d[16:1];
      end
      TSD_MX_SWAP: begin
        r.a = p.b;
        r.b = p.a;
      end
      TSD_MX_INV_B: r.b = neg_sat(p.b);
      TSD_MX_INV_A: r.a = neg_sat(p.a);
      TSD_MX_A_ONLY: r.b = p.a;
      TSD_MX_B_ONLY: r.a = p.b;
      default: r = p;
    endcase
    return r;
  endfunction

  // Scale one line-out sample by the volume byte under the chosen law.
  function automatic tsd_sample_t vol_scale(input tsd_sample_t x, input logic [7:0] v,
                                            input logic [3:0] law);
    logic signed [31:0] prod;
    logic [7:0]         steps;
    prod  = (32'(x) * $signed({24'h000000, v})) >>> TSD_VOL_SHIFT;
    steps = (TSD_VOL_UNITY - v) >> 3;
    if (v == 8'h00) begin
      vol_scale = 16'sh0000;
    end else if (law == TSD_LAW_LOG && v < TSD_VOL_UNITY) begin
      // Log law: each eight steps below unity cost one 6 dB shift.
      vol_scale = x >>> steps;
    end else begin
      vol_scale = sat16(prod);
    end
  endfunction

  // One step of the DC tracking filter.
  function automatic logic [31:0] dc_step(input logic [31:0] acc, input tsd_sample_t x);
    dc_step = 32'($signed(acc) + 32'(x) - ($signed(acc) >>> DC_SHIFT));
  endfunction

  function automatic tsd_sample_t dc_level(input logic [31:0] acc);
    dc_level = sat16($signed(acc) >>> DC_SHIFT);
  endfunction

  // Pick source 0 or 1 from the high byte of a routing word; only two exist here.
  function automatic tsd_pair_t pick_src(input tsd_pair_t [1:0] src, input logic [15:0] w);
    pick_src = (w[15:8] == 8'h01) ? src[1] : src[0];
  endfunction

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Next-state logic for the whole register bank and datapath.
  always_comb begin
    logic [31:0] acc1_new;
    logic [31:0] acc2_new;
    acc1_new  = dc_step(state_r.acc_one, i_fm_one);
    acc2_new  = dc_step(state_r.acc_two, i_fm_two);
    state_nxt = state_r;
    state_nxt.ident_clear = 1'b0;
    state_nxt.rd_valid    = 1'b0;
    state_nxt.nicam_curve = 1'b1;
    state_nxt.stereo_lvl  = i_stereo_level;

    // Host word writes; the read-only words have no case and are left alone.
    if (i_wr_stb) begin
      unique case (i_addr)
        TSD_ADDR_LINE_VOL:   state_nxt.line_vol_word  = i_wdata;
        TSD_ADDR_SPK_ROUTE:  state_nxt.route_word[0]  = i_wdata;
        TSD_ADDR_LINE_ROUTE: state_nxt.route_word[1]  = i_wdata;
        TSD_ADDR_SER_ROUTE:  state_nxt.route_word[2]  = i_wdata;
        TSD_ADDR_PEAK_ROUTE: state_nxt.route_word[3]  = i_wdata;
        TSD_ADDR_FM_SOURCE_MATRIX:  state_nxt.fm_source_matrix_word = i_wdata;
        TSD_ADDR_DEEMPH:     state_nxt.deemph_word    = i_wdata;
        TSD_ADDR_DC_FILTER:  state_nxt.dc_word        = i_wdata;
        TSD_ADDR_IDENT: begin
          // The clear code pulses the filter reset and leaves the mode as it was.
          if (i_wdata[7:0] == TSD_CODE_OFF) begin
            state_nxt.ident_clear = 1'b1;
          end else begin
            state_nxt.ident_word = i_wdata;
          end
        end
        default: state_nxt.dc_word = state_r.dc_word;
      endcase
    end

    // Standard selection and automatic sound select reload after a host write,
    // so the device's own choice wins a collision in the same cycle.
    if (i_std_load || (i_auto_upd && i_auto_select)) begin
      state_nxt.deemph_word = {i_std_cfg.deemph, i_std_cfg.adaptive};
      state_nxt.ident_word  = {8'h00, i_std_cfg.ident};
    end

    // NICAM standards keep the Fm_source_matrix refreshed to mono A.
    if (i_nicam_std) begin
      state_nxt.fm_source_matrix_word[7:0] = TSD_FM_SOUND_A_MONO;
    end

    // Channel matrices, with line-out volume applied after routing.
    state_nxt.route_valid = i_src_valid;
    if (i_src_valid) begin
      for (int i = 0; i < 4; i++) begin
        state_nxt.route[i] = route_pair(pick_src(i_src, state_r.route_word[i]),
                                        state_r.route_word[i][7:0]);
      end
      state_nxt.route[1].a = vol_scale(state_nxt.route[1].a, state_r.line_vol_word[15:8],
                                       state_r.line_vol_word[3:0]);
      state_nxt.route[1].b = vol_scale(state_nxt.route[1].b, state_r.line_vol_word[15:8],
                                       state_r.line_vol_word[3:0]);
    end

    // DC measurement runs whatever the filter word says, but channel two's holds while NICAM is enabled; removal follows the DC filter word.
    state_nxt.fm_valid = i_fm_valid;
    if (i_fm_valid) begin
      state_nxt.acc_one = acc1_new;
      if (!i_nicam_enable) begin
        state_nxt.acc_two = acc2_new;
      end
      if (state_r.dc_word[7:0] != TSD_CODE_OFF) begin
        state_nxt.fm_one_clean = sat16(32'(i_fm_one) - 32'(dc_level(acc1_new)));
        state_nxt.fm_two_clean = sat16(32'(i_fm_two) - 32'(dc_level(acc2_new)));
      end else begin
        state_nxt.fm_one_clean = i_fm_one;
        state_nxt.fm_two_clean = i_fm_two;
      end
      // The second FM path is silenced while NICAM occupies it.
      if (i_nicam_enable) begin
        state_nxt.fm_two_clean = 16'sh0000;
      end
    end

    // Word reads answer one cycle after the strobe; unmapped and write-only words read zero.
    if (i_rd_stb) begin
      state_nxt.rd_valid = 1'b1;
      unique case (i_addr)
        TSD_ADDR_STEREO_LVL: state_nxt.rdata = {state_r.stereo_lvl, 8'h00};
        TSD_ADDR_FM_ONE_DC:  state_nxt.rdata = dc_level(state_r.acc_one);
        TSD_ADDR_FM_TWO_DC:  state_nxt.rdata = dc_level(state_r.acc_two);
        default:             state_nxt.rdata = TSD_WORD_RESET;
      endcase
    end
  end

  // Single state register; all fields reset to zero except the fixed NICAM curve flag.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r             <= '0;
      state_r.nicam_curve <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs taken from the state register; ident mode and DC filter enable are decoded from it by compare.
  assign o_rd_valid           = state_r.rd_valid;
  assign o_rdata              = state_r.rdata;
  assign o_route              = state_r.route;
  assign o_route_valid        = state_r.route_valid;
  assign o_fm_one_clean       = state_r.fm_one_clean;
  assign o_fm_two_clean       = state_r.fm_two_clean;
  assign o_fm_valid           = state_r.fm_valid;
  assign o_fm_deemph          = state_r.deemph_word[15:8];
  assign o_ident_mode_m       = state_r.ident_word[7:0] == TSD_IDENT_M;
  assign o_ident_filter_clear = state_r.ident_clear;
  assign o_dc_filter_en       = state_r.dc_word[7:0] != TSD_CODE_OFF;
  assign o_nicam_curve_deemph = state_r.nicam_curve;
  assign o_fm_source_matrix          = state_r.fm_source_matrix_word[7:0];

  // Identification evaluation yields to adaptive deemphasis when both are asked for.
  assign o_adaptive_deemph_on = state_r.deemph_word[7:0] == TSD_CODE_OFF;
  assign o_ident_eval_en      = state_r.deemph_word[7:0] != TSD_CODE_OFF;

  // A standing NICAM enable excludes the second FM channel.
  logic nicam_en_r;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      nicam_en_r <= 1'b0;
    end else begin
      nicam_en_r <= i_nicam_enable;
    end
  end

  assign o_fm_two_enable = !nicam_en_r;

endmodule

// ===== tb/tsd_regs_props.sv
`timescale 1ns/10ps
// Watches the register port and the decoded controls of the register bank.
module tsd_regs_props
  import tsd_pkg::*;
(
  input wire logic         i_clk,
  input wire logic         i_nrst,
  input wire logic         i_wr_stb,
  input wire logic         i_rd_stb,
  input wire logic [15:0]  i_addr,
  input wire logic [15:0]  i_wdata,
  input wire logic         i_std_load,
  input wire logic         i_auto_upd,
  input wire logic         i_auto_select,
  input wire tsd_std_cfg_t i_std_cfg,
  input wire logic         i_nicam_std,
  input wire logic         i_nicam_enable,
  input wire logic [7:0]   i_stereo_level,
  input wire logic         o_rd_valid,
  input wire logic [15:0]  o_rdata,
  input wire logic [7:0]   o_fm_deemph,
  input wire logic         o_adaptive_deemph_on,
  input wire logic         o_ident_eval_en,
  input wire logic         o_ident_filter_clear,
  input wire logic         o_dc_filter_en,
  input wire logic         o_nicam_curve_deemph,
  input wire logic         o_fm_two_enable,
  input wire logic [7:0]   o_fm_source_matrix
);
  // A reload from standard selection beats a host write in the same cycle.
  logic ld;
  assign ld = i_std_load | (i_auto_upd & i_auto_select);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Control decodes and their causes.
  AST_CURVE: assert property (o_nicam_curve_deemph)
    else $error("nicam curve deemphasis dropped");
  AST_RD_VALID: assert property (i_rd_stb |=> o_rd_valid)
    else $error("read strobe without valid");
  AST_STEREO: assert property ((i_rd_stb && i_addr == TSD_ADDR_STEREO_LVL
    && $stable(i_stereo_level) && $past(i_stereo_level) == $past(i_stereo_level, 2))
    |=> o_rdata == {$past(i_stereo_level), 8'h00}) else $error("stereo level word wrong");
  AST_EXCL: assert property (o_ident_eval_en != o_adaptive_deemph_on)
    else $error("adaptive deemphasis and ident both on or both off");
  AST_NICAM_MX: assert property (i_nicam_std |=> o_fm_source_matrix == 8'h03)
    else $error("fm_source_matrix not forced to mono");
  AST_FM2_OFF: assert property (i_nicam_enable |=> !o_fm_two_enable)
    else $error("second fm path left on");
  AST_STD_LOAD: assert property (i_std_load |=> o_fm_deemph == $past(i_std_cfg.deemph)
    && o_adaptive_deemph_on == ($past(i_std_cfg.adaptive) == 8'h3F)) else $error("load lost");
  AST_HOLD: assert property (!ld && !(i_wr_stb && i_addr == TSD_ADDR_DEEMPH)
    |=> $stable(o_fm_deemph)) else $error("deemphasis changed unasked");
  AST_IDENT_CLR: assert property (i_wr_stb && i_addr == TSD_ADDR_IDENT && !ld
    |=> o_ident_filter_clear == ($past(i_wdata[7:0]) == 8'h3F)) else $error("ident clear");
  AST_DC_FILT: assert property (i_wr_stb && i_addr == TSD_ADDR_DC_FILTER
    |=> o_dc_filter_en == ($past(i_wdata[7:0]) != 8'h3F)) else $error("dc filter control");

  // Main scenarios reached.
  cover property (i_auto_upd && i_auto_select);
  cover property (o_ident_filter_clear);
  cover property (i_rd_stb && i_addr == TSD_ADDR_FM_TWO_DC);
endmodule

bind tsd_regs tsd_regs_props u_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata), .i_std_load(i_std_load),
  .i_auto_upd(i_auto_upd), .i_auto_select(i_auto_select), .i_std_cfg(i_std_cfg),
  .i_nicam_std(i_nicam_std), .i_nicam_enable(i_nicam_enable),
  .i_stereo_level(i_stereo_level), .o_rd_valid(o_rd_valid), .o_rdata(o_rdata),
  .o_fm_deemph(o_fm_deemph), .o_adaptive_deemph_on(o_adaptive_deemph_on),
  .o_ident_eval_en(o_ident_eval_en), .o_ident_filter_clear(o_ident_filter_clear),
  .o_dc_filter_en(o_dc_filter_en), .o_nicam_curve_deemph(o_nicam_curve_deemph),
  .o_fm_two_enable(o_fm_two_enable), .o_fm_source_matrix(o_fm_source_matrix));

// ===== tb/tsd_regs_tb_top.sv
`timescale 1ns/10ps
module tsd_regs_tb_top;
  import tsd_pkg::*;
  // Every input starts quiet at time zero; the bench drives them on falling edges.
  logic            clk = 0, nrst = 0, wr = 0, rd = 0, ld = 0, au = 0, asel = 0;
  logic            nstd = 0, nen = 0, sv = 0, fv = 0;
  logic [15:0]     addr = '0, wd = '0, rdat, q;
  logic [7:0]      slv = '0, dm, fmx;
  tsd_std_cfg_t    cfg = '0;
  tsd_pair_t [1:0] src = '0;
  tsd_pair_t [3:0] route;
  tsd_sample_t     f1 = '0, f2 = '0, c1, c2;
  logic            rv, rtv, fov, ad, ie, im, ifc, dce, cur, f2e;
  logic [31:0]     rnd = 32'h9E46;
  int              fail_count = 0, cmp_count = 0, cyc = 0;
  logic [15:0]     rt [3] = '{TSD_ADDR_SPK_ROUTE, TSD_ADDR_SER_ROUTE, TSD_ADDR_PEAK_ROUTE};
  int              ri [3] = '{0, 2, 3};
  logic [15:0]     vw [3] = '{16'h4000, 16'h0000, 16'h4001};
  logic [7:0]      dc [4] = '{8'h00, 8'h01, 8'h04, 8'h3F};
  logic [7:0]      sl [3] = '{8'h7F, 8'h80, 8'h00};

  // A small FS_HZ keeps the DC settling short enough to converge in a few dozen samples.
  tsd_regs #(.FS_HZ(100)) dut (
    .i_clk(clk), .i_nrst(nrst), .i_wr_stb(wr), .i_rd_stb(rd), .i_addr(addr),
    .i_wdata(wd), .o_rd_valid(rv), .o_rdata(rdat), .i_std_load(ld), .i_auto_upd(au),
    .i_auto_select(asel), .i_std_cfg(cfg), .i_nicam_std(nstd), .i_nicam_enable(nen),
    .i_src(src), .i_src_valid(sv), .i_fm_one(f1), .i_fm_two(f2), .i_fm_valid(fv),
    .i_stereo_level(slv), .o_route(route), .o_route_valid(rtv), .o_fm_one_clean(c1),
    .o_fm_two_clean(c2), .o_fm_valid(fov), .o_fm_deemph(dm), .o_adaptive_deemph_on(ad),
    .o_ident_eval_en(ie), .o_ident_mode_m(im), .o_ident_filter_clear(ifc),
    .o_dc_filter_en(dce), .o_nicam_curve_deemph(cur), .o_fm_two_enable(f2e),
    .o_fm_source_matrix(fmx));

  // Clock and a hang guard well above the expected run length.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Inverting saturates, since the most negative sample has no positive twin.
  function automatic tsd_sample_t ng(input tsd_sample_t x);
    ng = (x == 16'sh8000) ? 16'sh7FFF : -x;
  endfunction

  function automatic tsd_pair_t mx(input logic [7:0] c, input tsd_pair_t p);
    logic signed [16:0] s, d;
    s = p.a + p.b;
    d = p.a - p.b;
    case (c)
      8'h40: mx = {s[16:1], d[16:1]};
      8'h50: mx = {p.b, p.a};
      8'h60: mx = {p.a, ng(p.b)};
      8'h70: mx = {ng(p.a), p.b};
      8'h80: mx = {p.a, p.a};
      default: mx = {p.b, p.b};
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_w(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask

  task automatic rd_w(input logic [15:0] a);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    chk("rd_valid", 1, rv);
    q = rdat;
  endtask

  task automatic au_s();
    @(negedge clk);
    rnd = nxt(rnd);
    src[0] = rnd;
    rnd = nxt(rnd);
    src[1] = rnd;
    sv = 1;
    @(negedge clk);
    sv = 0;
  endtask

  task automatic fm_s(input tsd_sample_t x, input tsd_sample_t y);
    @(negedge clk);
    f1 = x;
    f2 = y;
    fv = 1;
    @(negedge clk);
    fv = 0;
  endtask

  task automatic strobe(input logic k);
    @(negedge clk);
    ld = !k;
    au = k;
    @(negedge clk);
    ld = 0;
    au = 0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence: reset, then one group of checks per feature.
  initial begin
    logic [7:0] c;
    logic       b;
    repeat (4) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    chk("reset_ctl", {8'h00, 5'b00111}, {dm, ad, im, dce, cur, f2e});
    $display("test reset done");
    for (int i = 0; i < 18; i++) begin
      c = 8'h40 + 8'h10 * 8'(i % 6);
      rnd = nxt(rnd);
      b = rnd[0];
      wr_w(rt[i / 6], {7'h00, b, c});
      au_s();
      chk("route", mx(c, src[b]), route[ri[i / 6]]);
    end
    $display("test matrix done");
    wr_w(TSD_ADDR_LINE_ROUTE, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      wr_w(TSD_ADDR_LINE_VOL, vw[i]);
      au_s();
      chk("line_out", {src[0].a, src[0].a} & {32{i != 1}}, route[1]);
    end
    $display("test volume done");
    cfg = '{8'h01, 8'h3F, 8'h01};
    strobe(0);
    chk("std_load", {8'h01, 3'b101}, {dm, ad, ie, im});
    cfg = '{8'h04, 8'h00, 8'h00};
    strobe(1);
    chk("auto_off", {8'h01, 3'b101}, {dm, ad, ie, im});
    asel = 1;
    strobe(1);
    chk("auto_on", {8'h04, 3'b010}, {dm, ad, ie, im});
    foreach (dc[i]) begin
      rnd = nxt(rnd);
      c = rnd[0] ? 8'h3F : 8'h00;
      wr_w(TSD_ADDR_DEEMPH, {dc[i], c});
      chk("deemph", {dc[i], c == 8'h3F, c != 8'h3F}, {dm, ad, ie});
    end
    $display("test deemphasis done");
    wr_w(TSD_ADDR_IDENT, 16'h0001);
    wr_w(TSD_ADDR_IDENT, 16'h003F);
    chk("ident_clr", 2'b11, {ifc, im});
    wr_w(TSD_ADDR_IDENT, 16'h0000);
    chk("ident_bg", 2'b00, {ifc, im});
    $display("test ident done");
    wr_w(TSD_ADDR_DC_FILTER, 16'h0000);
    repeat (60) fm_s(16'sh012C, 16'shFE0C);
    chk("clean", 0, {c1, c2});
    rd_w(TSD_ADDR_FM_ONE_DC);
    chk("dc_one", 16'h012C, q);
    rd_w(TSD_ADDR_FM_TWO_DC);
    chk("dc_two", 16'hFE0C, q);
    wr_w(TSD_ADDR_FM_ONE_DC, 16'h1234);
    rd_w(TSD_ADDR_FM_ONE_DC);
    chk("dc_ro", 16'h012C, q);
    wr_w(TSD_ADDR_DC_FILTER, 16'h003F);
    fm_s(16'sh012C, 16'sh012C);
    chk("raw", {16'h012C, 16'h012C}, {c1, c2});
    chk("dc_off", 0, dce);
    $display("test dc done");
    foreach (sl[i]) begin
      slv = sl[i];
      repeat (3) @(negedge clk);
      rd_w(TSD_ADDR_STEREO_LVL);
      chk("stereo", {sl[i], 8'h00}, q);
    end
    rd_w(16'h0030);
    chk("unmapped", 0, q);
    $display("test readback done");
    nstd = 1;
    wr_w(TSD_ADDR_FM_SOURCE_MATRIX, 16'h0000);
    @(negedge clk);
    chk("fm_source_matrix", 8'h03, fmx);
    nstd = 0;
    wr_w(TSD_ADDR_FM_SOURCE_MATRIX, {8'h00, TSD_FM_SOUND_A_MONO});
    chk("fm_mono", 8'h03, fmx);
    nen = 1;
    fm_s(16'sh0064, 16'sh0064);
    chk("fm_two", {16'h0064, 16'h0000, 1'b0}, {c1, c2, f2e});
    nen = 0;
    $display("test nicam done");
    give_verdict();
  end
endmodule
